// file: hdl/tsl_regs.svh
// Register map, field positions, reset values and timing figures of the sensor register bank
`ifndef TSL_REGS_SVH
`define TSL_REGS_SVH
// ****************************************************************
// Register addresses
// ****************************************************************
`define TSL_A_TEMP    4'h0
`define TSL_A_CFG     4'h1
`define TSL_A_UPPER   4'h2
`define TSL_A_LOWER   4'h3
`define TSL_A_UNLOCK  4'h4
`define TSL_A_SCR1    4'h5
`define TSL_A_SCR2    4'h6
// ****************************************************************
// Field positions
// ****************************************************************
`define TSL_B_HI      15
`define TSL_B_LO      14
`define TSL_B_DRDY    13
`define TSL_B_BUSY    12
`define TSL_B_MOD1    11
`define TSL_B_UNLOCK  15
`define TSL_B_UBUSY   14
// ****************************************************************
// Reset values and codes
// ****************************************************************
`define TSL_RST_CFG   16'h0220
`define TSL_RST_UPPER 16'h6000
`define TSL_RST_LOWER 16'h8000
`define TSL_CFG_WMASK 16'h0FFC
`define TSL_MOD_SD    2'h1
`define TSL_MOD_OS    2'h3
`define TSL_MOD_ALIAS 2'h2
// ****************************************************************
// Timing: clock, tick and periods in half-millisecond ticks
// ****************************************************************
`define TSL_CLK_NS    40
`define TSL_TICK_NS   500000
`define TSL_ACT_AVG0  16'd31
`define TSL_ACT_AVG1  16'd250
`define TSL_ACT_AVG2  16'd1000
`define TSL_ACT_AVG3  16'd2000
`define TSL_PER_1     16'd250
`define TSL_PER_2     16'd500
`define TSL_PER_3     16'd1000
`define TSL_PER_4     16'd2000
`define TSL_PER_5     16'd8000
`define TSL_PER_6     16'd16000
`define TSL_PER_7     16'd32000
`endif

// file: hdl/tsl_pkg.sv
// Types shared by the sensor register bank
package tsl_pkg;
  typedef enum logic [1:0] {
    TSL_IDLE    = 2'b00,
    TSL_ACTIVE  = 2'b01,
    TSL_STANDBY = 2'b10
  } tsl_state_e;

  typedef struct packed {
    tsl_state_e        state;
    logic [15:0]       tick_cnt;
    logic [15:0]       phase_cnt;
    logic [6:0]        samp_cnt;
    logic [22:0]       acc;
    logic [15:0]       temp;
    logic              hi;
    logic              lo;
    logic              drdy;
    logic [11:2]       cfg;
    logic [15:0]       upper;
    logic [15:0]       lower;
    logic              unlock;
    logic [15:0]       scr1;
    logic [15:0]       scr2;
    logic [4:0][15:0]  nvm;
    logic              busy;
    logic              loading;
    logic [15:0]       busy_cnt;
    logic [15:0]       rdata;
    logic              conv_run;
    logic              alert;
  } tsl_state_s;
endpackage

// file: hdl/tsl_top.sv
// Sensor register bank: scheduler, averaging, thresholds and non-volatile copies
//
// What this block does
// - Averages 1, 8, 32 or 64 samples per result for averaging codes 00..11.
// - Period code 000 in continuous mode runs conversions back to back with no standby.
// - Codes 001..100 ask for 125/250/500/1000 ms, stretched to the active time if longer.
// - Codes 101..111 give 4/8/16 s and standby fills the period less the active time.
// - A 16-bit upper threshold is kept and compared with each result.
// - The upper threshold reloads from its stored copy at reset; the factory copy is 6000h.
// - A 16-bit lower threshold reloads from its stored copy; the factory copy is 8000h.
// - With the unlock bit clear, writes change only the working registers.
// - With the unlock bit set, each write to a writable register while busy is clear programs its stored copy.
// - Unlock bit 14 mirrors the busy flag and bits 13:0 read zero.
// - Busy reads 1 during programming or reload and 0 once done.
// - Two 16-bit scratch registers at 05h and 06h have stored copies and the same locking.
// - Alert mode sets upper and lower crossing flags and a configuration read clears them.
// - Therm mode sets the upper flag above the upper limit, clears it below the lower one.
`timescale 1ns/1ps
`default_nettype none
`include "tsl_regs.svh"
module tsl_top #(
  parameter int          TICK_CYCLES = `TSL_TICK_NS / `TSL_CLK_NS,
  parameter logic [15:0] PROG_CYCLES = 16'd100,
  parameter logic [15:0] LOAD_CYCLES = 16'd100,
  parameter logic [15:0] SCR1_INIT   = 16'h0000,
  parameter logic [15:0] SCR2_INIT   = 16'h0000
) (
  input  wire logic        clk,       // 25 MHz clock
  input  wire logic        rstn,      // Power-up reset, active low
  input  wire logic        gcall,     // General-call reset pulse
  input  wire logic        wr_en,     // Register write strobe
  input  wire logic        rd_en,     // Register read strobe
  input  wire logic [3:0]  addr,      // Register address
  input  wire logic [15:0] wdata,     // Write data
  input  wire logic        raw_valid, // Converter sample strobe
  input  wire logic [15:0] raw_data,  // Converter sample
  output logic      [15:0] rdata,     // Read data, one cycle after rd_en
  output logic             conv_run,  // Converter active phase
  output logic             alert_out  // Alert pin level
);
  tsl_pkg::tsl_state_s st_r, st_nxt;

  // ****************************************************************
  // Lookup functions
  // ****************************************************************
  // Number of samples per result
  function automatic logic [6:0] avg_count(input logic [1:0] a);
    case (a)
      2'b00:   avg_count = 7'd1;
      2'b01:   avg_count = 7'd8;
      2'b10:   avg_count = 7'd32;
      default: avg_count = 7'd64;
    endcase
  endfunction

  // Divide by the sample count as a shift
  function automatic logic [2:0] avg_shift(input logic [1:0] a);
    case (a)
      2'b00:   avg_shift = 3'd0;
      2'b01:   avg_shift = 3'd3;
      2'b10:   avg_shift = 3'd5;
      default: avg_shift = 3'd6;
    endcase
  endfunction

  // Active conversion time in ticks
  function automatic logic [15:0] act_ticks(input logic [1:0] a);
    case (a)
      2'b00:   act_ticks = `TSL_ACT_AVG0;
      2'b01:   act_ticks = `TSL_ACT_AVG1;
      2'b10:   act_ticks = `TSL_ACT_AVG2;
      default: act_ticks = `TSL_ACT_AVG3;
    endcase
  endfunction

  // Cycle period in ticks, never shorter than the active time
  function automatic logic [15:0] period_ticks(input logic [2:0] c, input logic [1:0] a);
    logic [15:0] req;
    case (c)
      3'b001:  req = `TSL_PER_1;
      3'b010:  req = `TSL_PER_2;
      3'b011:  req = `TSL_PER_3;
      3'b100:  req = `TSL_PER_4;
      3'b101:  req = `TSL_PER_5;
      3'b110:  req = `TSL_PER_6;
      3'b111:  req = `TSL_PER_7;
      default: req = act_ticks(a);
    endcase
    period_ticks = (req > act_ticks(a)) ? req : act_ticks(a);
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  logic [1:0]  mode;
  logic [2:0]  conv;
  logic [1:0]  avg;
  logic        tick;
  logic [15:0] standby;
  logic [22:0] acc_sum;
  logic [22:0] avg_val;
  logic [15:0] res;
  logic        writable;
  logic        res_valid;

  always_comb
  begin
    st_nxt    = st_r;
    mode      = st_r.cfg[11:10];
    conv      = st_r.cfg[9:7];
    avg       = st_r.cfg[6:5];
    tick      = (st_r.tick_cnt == 16'(TICK_CYCLES - 1));
    standby   = period_ticks(conv, avg) - act_ticks(avg);
    acc_sum   = st_r.acc + {{7{raw_data[15]}}, raw_data};
    avg_val   = 23'($signed(acc_sum) >>> avg_shift(avg));
    res       = avg_val[15:0];
    res_valid = 1'b0;
    writable  = (addr == `TSL_A_CFG) || (addr == `TSL_A_UPPER) || (addr == `TSL_A_LOWER) ||
                (addr == `TSL_A_SCR1) || (addr == `TSL_A_SCR2);

    // Tick divider, runs freely so periods need no restart logic
    st_nxt.tick_cnt = tick ? 16'h0000 : st_r.tick_cnt + 16'h0001;

    // Conversion scheduler
    case (st_r.state)
      tsl_pkg::TSL_IDLE:
      begin
        if (mode != `TSL_MOD_SD && !st_r.loading)
        begin
          st_nxt.state     = tsl_pkg::TSL_ACTIVE;
          st_nxt.phase_cnt = act_ticks(avg) - 16'h0001;
          st_nxt.samp_cnt  = 7'd0;
          st_nxt.acc       = 23'h00_0000;
        end
      end
      tsl_pkg::TSL_ACTIVE:
      begin
        if (tick && st_r.phase_cnt == 16'h0000)
        begin
          if (mode == `TSL_MOD_OS)
          begin
            st_nxt.state         = tsl_pkg::TSL_IDLE;
            st_nxt.cfg[11:10]    = `TSL_MOD_SD;
          end
          else if (standby != 16'h0000)
          begin
            st_nxt.state     = tsl_pkg::TSL_STANDBY;
            st_nxt.phase_cnt = standby - 16'h0001;
          end
          else
          begin
            st_nxt.phase_cnt = act_ticks(avg) - 16'h0001;
            st_nxt.samp_cnt  = 7'd0;
            st_nxt.acc       = 23'h00_0000;
          end
        end
        else if (tick)
          st_nxt.phase_cnt = st_r.phase_cnt - 16'h0001;
        if (raw_valid)
        begin
          if (st_r.samp_cnt == avg_count(avg) - 7'd1)
          begin
            res_valid       = 1'b1;
            st_nxt.temp     = res;
            st_nxt.samp_cnt = 7'd0;
            st_nxt.acc      = 23'h00_0000;
          end
          else
          begin
            st_nxt.samp_cnt = st_r.samp_cnt + 7'd1;
            st_nxt.acc      = acc_sum;
          end
        end
      end
      tsl_pkg::TSL_STANDBY:
      begin
        if (tick && st_r.phase_cnt == 16'h0000)
        begin
          st_nxt.state     = tsl_pkg::TSL_ACTIVE;
          st_nxt.phase_cnt = act_ticks(avg) - 16'h0001;
          st_nxt.samp_cnt  = 7'd0;
          st_nxt.acc       = 23'h00_0000;
        end
        else if (tick)
          st_nxt.phase_cnt = st_r.phase_cnt - 16'h0001;
      end
      default: st_nxt.state = tsl_pkg::TSL_IDLE;
    endcase
    if (mode == `TSL_MOD_SD)
      st_nxt.state = tsl_pkg::TSL_IDLE;

    // Register reads; reading clears flags before new results so a fresh event wins
    if (rd_en)
    begin
      case (addr)
        `TSL_A_TEMP:   st_nxt.rdata = st_r.temp;
        `TSL_A_CFG:    st_nxt.rdata = {st_r.hi, st_r.lo, st_r.drdy, st_r.busy, st_r.cfg, 2'b00};
        `TSL_A_UPPER:  st_nxt.rdata = st_r.upper;
        `TSL_A_LOWER:  st_nxt.rdata = st_r.lower;
        `TSL_A_UNLOCK: st_nxt.rdata = {st_r.unlock, st_r.busy, 14'h0000};
        `TSL_A_SCR1:   st_nxt.rdata = st_r.scr1;
        `TSL_A_SCR2:   st_nxt.rdata = st_r.scr2;
        default:       st_nxt.rdata = 16'h0000;
      endcase
      if (addr == `TSL_A_TEMP || addr == `TSL_A_CFG)
        st_nxt.drdy = 1'b0;
      if (addr == `TSL_A_CFG && !st_r.cfg[4])
      begin
        st_nxt.hi = 1'b0;
        st_nxt.lo = 1'b0;
      end
    end

    // Threshold comparison on each new result
    if (res_valid)
    begin
      st_nxt.drdy = 1'b1;
      if (st_r.cfg[4])
      begin
        if ($signed(res) > $signed(st_r.upper))
          st_nxt.hi = 1'b1;
        else if ($signed(res) < $signed(st_r.lower))
          st_nxt.hi = 1'b0;
      end
      else
      begin
        if ($signed(res) > $signed(st_r.upper))
          st_nxt.hi = 1'b1;
        if ($signed(res) < $signed(st_r.lower))
          st_nxt.lo = 1'b1;
      end
    end
    if (st_r.cfg[4])
      st_nxt.lo = 1'b0;

    // Register writes, ignored while the stored copies are busy
    if (wr_en && !st_r.busy)
    begin
      case (addr)
        `TSL_A_CFG:
        begin
          st_nxt.cfg = 10'((wdata & `TSL_CFG_WMASK) >> 2);
          if (wdata[11:10] == `TSL_MOD_ALIAS)
            st_nxt.cfg[11:10] = 2'b00;
        end
        `TSL_A_UPPER:  st_nxt.upper  = wdata;
        `TSL_A_LOWER:  st_nxt.lower  = wdata;
        `TSL_A_UNLOCK: st_nxt.unlock = wdata[`TSL_B_UNLOCK];
        `TSL_A_SCR1:   st_nxt.scr1   = wdata;
        `TSL_A_SCR2:   st_nxt.scr2   = wdata;
        default:       st_nxt.unlock = st_r.unlock;
      endcase
      if (st_r.unlock && writable)
      begin
        st_nxt.busy     = 1'b1;
        st_nxt.busy_cnt = PROG_CYCLES;
        case (addr)
          `TSL_A_CFG:   st_nxt.nvm[0] = wdata & ~(16'h0001 << `TSL_B_MOD1);
          `TSL_A_UPPER: st_nxt.nvm[1] = wdata;
          `TSL_A_LOWER: st_nxt.nvm[2] = wdata;
          `TSL_A_SCR1:  st_nxt.nvm[3] = wdata;
          default:      st_nxt.nvm[4] = wdata;
        endcase
      end
    end

    // General-call reset starts a reload from the stored copies
    if (gcall)
    begin
      st_nxt.loading  = 1'b1;
      st_nxt.busy     = 1'b1;
      st_nxt.busy_cnt = LOAD_CYCLES;
      st_nxt.state    = tsl_pkg::TSL_IDLE;
    end
    else if (st_r.busy)
    begin
      if (st_r.busy_cnt == 16'h0000)
      begin
        st_nxt.busy    = 1'b0;
        st_nxt.loading = 1'b0;
        if (st_r.loading)
        begin
          st_nxt.cfg   = st_r.nvm[0][11:2];
          st_nxt.upper = st_r.nvm[1];
          st_nxt.lower = st_r.nvm[2];
          st_nxt.scr1  = st_r.nvm[3];
          st_nxt.scr2  = st_r.nvm[4];
        end
      end
      else
        st_nxt.busy_cnt = st_r.busy_cnt - 16'h0001;
    end

    // Registered outputs; alert pin follows polarity and source select
    st_nxt.conv_run = (st_nxt.state == tsl_pkg::TSL_ACTIVE);
    st_nxt.alert    = (st_nxt.cfg[2] ? st_nxt.drdy : (st_nxt.hi | st_nxt.lo)) ~^ st_nxt.cfg[3];
  end

  // State register; power-up reset loads the factory image then reloads from it
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st_r          <= '0;
      st_r.cfg      <= 10'(`TSL_RST_CFG >> 2);
      st_r.upper    <= `TSL_RST_UPPER;
      st_r.lower    <= `TSL_RST_LOWER;
      st_r.nvm      <= {SCR2_INIT, SCR1_INIT, `TSL_RST_LOWER, `TSL_RST_UPPER, `TSL_RST_CFG};
      st_r.scr1     <= SCR1_INIT;
      st_r.scr2     <= SCR2_INIT;
      st_r.busy     <= 1'b1;
      st_r.loading  <= 1'b1;
      st_r.busy_cnt <= LOAD_CYCLES;
      st_r.alert    <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign rdata     = st_r.rdata;
  assign conv_run  = st_r.conv_run;
  assign alert_out = st_r.alert;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_unlock_low_zero: assert property (rd_en && addr == `TSL_A_UNLOCK |=> rdata[13:0] == 14'h0000 && rdata[14] == $past(st_r.busy))
    else $error("unlock register low bits or busy mirror wrong");
  a_lock_no_prog: assert property (wr_en && !gcall && !st_r.busy && !st_r.unlock && writable |=> !st_r.busy)
    else $error("locked write started programming");
  a_unlock_prog: assert property (wr_en && !st_r.busy && st_r.unlock && writable |=> st_r.busy [*3])
    else $error("unlocked write did not hold busy");
  a_upper_reset: assert property ($rose(rstn) |-> st_r.upper == `TSL_RST_UPPER && st_r.busy)
    else $error("upper threshold not at factory value after reset");
  a_lower_reset: assert property ($rose(rstn) |-> st_r.lower == `TSL_RST_LOWER)
    else $error("lower threshold not at factory value after reset");
  a_therm_lo_zero: assert property (st_r.cfg[4] && $past(st_r.cfg[4]) |-> !st_r.lo)
    else $error("lower flag set in therm mode");
  a_cfg_read_clr: assert property (rd_en && addr == `TSL_A_CFG && !st_r.cfg[4] && !raw_valid |=> !st_r.hi && !st_r.lo)
    else $error("configuration read did not clear flags");
  a_zero_standby: assert property (st_r.state == tsl_pkg::TSL_ACTIVE && st_r.cfg[11:7] == 5'b00000 && !gcall |=> st_r.state != tsl_pkg::TSL_STANDBY)
    else $error("standby entered with period code zero");
  a_avg_update: assert property (st_r.state == tsl_pkg::TSL_ACTIVE && raw_valid && st_r.samp_cnt == avg_count(st_r.cfg[6:5]) - 7'd1 |=> st_r.drdy && st_r.samp_cnt == 7'd0)
    else $error("result not updated after the sample count");
  a_busy_done: assert property (st_r.busy && st_r.busy_cnt == 16'h0000 && !gcall |=> !st_r.busy)
    else $error("busy not released at end of operation");
endmodule
`default_nettype wire

// file: dv/tsl_host_model.sv
// Host-side register master that stands on the far side of the sensor register bank
`timescale 1ns/1ps
`default_nettype none
`include "tsl_regs.svh"
module tsl_host_model (
  input  wire logic        clk,   // Bus clock
  input  wire logic [15:0] rdata, // Read data from the bank
  output logic             wr_en, // Write strobe
  output logic             rd_en, // Read strobe
  output logic      [3:0]  addr,  // Register address
  output logic      [15:0] wdata  // Write data
);
  logic unlocked = 1'b0;
  // ****************************************************************
  // Bus cycles: callers enter just after a rising edge
  // ****************************************************************
  // Idle bus at time zero
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 4'hF;
    wdata = 16'h0000;
  end

  // Read data is taken at the edge that takes the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    rd_en = 1'b1;
    addr  = a;
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    addr  = 4'hF; // Released address points at nothing mapped
    d     = rdata;
    @(posedge clk); // Idle edge so a following call never re-raises the strobe at once
    #1;
  endtask

  // Poll the busy mirror, bounded so a stuck flag cannot hang the host
  task automatic wait_idle();
    logic [15:0] d;
    int          n;
    n = 0;
    d = 16'hFFFF;
    while (d[`TSL_B_UBUSY] !== 1'b0 && n < 200)
    begin
      rd(`TSL_A_UNLOCK, d);
      n++;
    end
  endtask

  // Scratch copies are programmed only when a scenario asks for it
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    if (unlocked)
      wait_idle();
    wr_en = 1'b1;
    addr  = a;
    wdata = d;
    @(posedge clk);
    #1;
    wr_en = 1'b0;
    addr  = 4'hF;
    wdata = ~d; // Stale data never lingers on a released bus
    if (a == `TSL_A_UNLOCK)
      unlocked = d[`TSL_B_UNLOCK];
    @(posedge clk); // Idle edge between back-to-back writes
    #1;
  endtask
endmodule
`default_nettype wire

// file: dv/thermal_sensor_limit_nvm_regs_test.sv
// Self-checking bench for the sensor register bank
`timescale 1ns/1ps
`default_nettype none
`include "tsl_regs.svh"
module thermal_sensor_limit_nvm_regs_test;
  localparam int TICK   = 2;
  localparam int NS [4] = '{1, 8, 32, 64};
  typedef struct { logic [3:0] a; logic [15:0] w; logic [15:0] e; } tsl_row_s;
  typedef struct { logic [15:0] c; int h; int p; } tsl_per_s;
  logic        clk;
  logic        rstn      = 1'b0;
  logic        gcall     = 1'b0;
  logic        raw_valid = 1'b0;
  logic [15:0] raw_data  = 16'h0000;
  logic        wr_en;
  logic        rd_en;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        conv_run;
  logic        alert_out;
  logic [15:0] d;
  int          n_mismatch = 0;
  int          checked    = 0;
  // Locked writes with read-back; the unlock row follows every writable row so nothing is programmed
  tsl_row_s rows [6] = '{'{4'h2, 16'h1234, 16'h1234}, '{4'h3, 16'hABCD, 16'hABCD},
                        '{4'h5, 16'h5A5A, 16'h5A5A}, '{4'h6, 16'hA5A5, 16'hA5A5},
                        '{4'h4, 16'h7FFF, 16'h0000}, '{4'hF, 16'h1234, 16'h0000}};
  // Period codes with standby, in clocks at the shortened tick
  tsl_per_s pers [3] = '{'{16'h0080, 62, 500}, '{16'h0120, 500, 1000},
                        '{16'h0280, 62, 16000}};

  tsl_top #(.TICK_CYCLES(TICK), .PROG_CYCLES(16'd3), .LOAD_CYCLES(16'd3)) uut (
    .clk(clk), .rstn(rstn), .gcall(gcall), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .raw_valid(raw_valid), .raw_data(raw_data), .rdata(rdata),
    .conv_run(conv_run), .alert_out(alert_out));

  tsl_host_model host (
    .clk(clk), .rdata(rdata), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata));

  // ****************************************************************
  // Clock, checking and closing
  // ****************************************************************
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [15:0] e, input string msg);
    host.rd(a, d);
    check(d, e, msg);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One converter strobe, then an idle clock so strobes never merge
  task automatic sample(input logic [15:0] v);
    raw_valid = 1'b1;
    raw_data  = v;
    cyc(1);
    raw_valid = 1'b0;
    raw_data  = ~v;
    cyc(1);
  endtask

  // Counts clocks until the active phase reaches the wanted level
  task automatic wait_run(input logic lvl, output int n);
    n = 0;
    while (conv_run !== lvl && n < 40000)
    begin
      cyc(1);
      n++;
    end
    if (n == 40000)
      check(16'(conv_run), 16'(lvl), "converter phase stuck");
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Longest period row dominates; the limit leaves a little over half again as margin
  initial
  begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset, table rows, stored copies, averaging with flags, periods
  initial
  begin
    int          n;
    int          hi;
    int          lo;
    logic [15:0] res;
    logic [15:0] cv;
    cyc(8);
    rstn = 1'b1;
    rdchk(`TSL_A_UNLOCK, 16'h4000, "busy during reload");
    host.wait_idle();
    rdchk(`TSL_A_UPPER, `TSL_RST_UPPER, "upper reset");
    rdchk(`TSL_A_LOWER, `TSL_RST_LOWER, "lower reset");
    rdchk(`TSL_A_CFG, `TSL_RST_CFG, "config reset");
    rdchk(`TSL_A_UNLOCK, 16'h0000, "unlock reset");
    foreach (rows[i])
    begin
      host.wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].e, "register read-back");
    end
    // Locked writes left the stored copies at factory values
    gcall = 1'b1;
    cyc(1);
    gcall = 1'b0;
    host.wait_idle();
    rdchk(`TSL_A_UPPER, `TSL_RST_UPPER, "locked write reached copy");
    rdchk(`TSL_A_SCR1, 16'h0000, "locked scratch reached copy");
    host.wr(`TSL_A_UNLOCK, 16'h8000);
    rdchk(`TSL_A_UNLOCK, 16'h8000, "unlock bit");
    host.wr(`TSL_A_SCR1, 16'hBEEF);
    rdchk(`TSL_A_UNLOCK, 16'hC000, "busy mirror while programming");
    host.wr(`TSL_A_UPPER, 16'h2222);
    host.wr(`TSL_A_UNLOCK, 16'h0000);
    host.wr(`TSL_A_SCR1, 16'h0000);
    host.wr(`TSL_A_UPPER, 16'h0001);
    gcall = 1'b1;
    cyc(1);
    gcall = 1'b0;
    host.wait_idle();
    rdchk(`TSL_A_SCR1, 16'hBEEF, "scratch copy programmed");
    rdchk(`TSL_A_UPPER, 16'h2222, "upper copy programmed");
    // Each averaging code: samples 4k average to 2(N-1), one flag per result
    host.wr(`TSL_A_UPPER, 16'h0030);
    host.wr(`TSL_A_LOWER, 16'h0010);
    for (int g = 0; g < 4; g++)
    begin
      cv = 16'(g << 5);
      host.wr(`TSL_A_CFG, 16'h0400);
      wait_run(1'b0, n);
      host.wr(`TSL_A_CFG, cv);
      wait_run(1'b1, n);
      for (int k = 0; k < NS[g]; k++)
        sample(16'(4 * k));
      res = 16'(2 * (NS[g] - 1));
      n = 0;
      while (alert_out !== 1'b0 && n < 1000)
      begin
        cyc(1);
        n++;
      end
      check(16'(alert_out), 16'h0000, "alert pin on crossing");
      rdchk(`TSL_A_CFG, {res > 16'h0030, res < 16'h0010, 2'b10, cv[11:0]}, "flags");
      rdchk(`TSL_A_TEMP, res, "averaged result");
      check(16'(alert_out), 16'h0001, "alert cleared by config read");
    end
    // Therm mode, alias run code, active-high pin: lower limit acts as hysteresis
    host.wr(`TSL_A_CFG, 16'h0400);
    wait_run(1'b0, n);
    host.wr(`TSL_A_CFG, 16'h0818);
    wait_run(1'b1, n);
    sample(16'h0040);
    check(16'(alert_out), 16'h0001, "therm alert active high");
    rdchk(`TSL_A_CFG, 16'hA018, "therm flag set, alias mode reads 00");
    sample(16'h0020);
    rdchk(`TSL_A_CFG, 16'hA018, "therm flag held above hysteresis");
    sample(16'h0000);
    rdchk(`TSL_A_CFG, 16'h2018, "therm flag cleared, lower flag zero");
    check(16'(alert_out), 16'h0000, "therm alert released");
    // One-shot with data ready on the pin: one active phase, then shutdown
    host.wr(`TSL_A_CFG, 16'h0C04);
    wait_run(1'b1, n);
    sample(16'h0020);
    check(16'(alert_out), 16'h0000, "data ready on active-low pin");
    wait_run(1'b0, n);
    rdchk(`TSL_A_CFG, 16'h2404, "one-shot ends in shutdown");
    check(16'(alert_out), 16'h0001, "data ready cleared by read");
    // Code 001 with 32 samples: period stretches to the active time, so no standby
    host.wr(`TSL_A_CFG, 16'h00C0);
    wait_run(1'b1, n);
    lo = 0;
    repeat (2500)
    begin
      cyc(1);
      if (conv_run !== 1'b1)
        lo++;
    end
    check(16'(lo), 16'h0000, "standby despite longer active time");
    // Active width and period, measured on a whole cycle after settling
    foreach (pers[i])
    begin
      host.wr(`TSL_A_CFG, pers[i].c);
      wait_run(1'b0, n);
      wait_run(1'b1, n);
      wait_run(1'b0, n);
      wait_run(1'b1, n);
      wait_run(1'b0, hi);
      wait_run(1'b1, lo);
      check(16'(hi), 16'(pers[i].h), "active width");
      check(16'(hi + lo), 16'(pers[i].p), "cycle period");
    end
    end_of_test();
  end
endmodule
`default_nettype wire
